/* shared/bot_regs.svh */
// constants and timing counts shared by both ends of the bit-stream link
`ifndef BOT_REGS_SVH
`define BOT_REGS_SVH

`define BOT_NSTREAM       4
`define BOT_DEPTH         32
`define BOT_BASE_TAP      16
`define BOT_OFS_MIN       (-16)
`define BOT_OFS_MAX       15
`define BOT_SETTLE_BITS   32
`define BOT_REC_DIV       4
`define BOT_LINK_NS       80
`define BOT_R1_MAX_NS     500
`define BOT_R1_MAX_CYC    (`BOT_R1_MAX_NS / `BOT_LINK_NS)
`define BOT_CLK_NS        100
`define BOT_TICK_NS       200
`define BOT_TICK_CYC      ((`BOT_TICK_NS + `BOT_CLK_NS - 1) / `BOT_CLK_NS)
`define BOT_STRETCH_CYC   64
`define BOT_PROC_IDLE_CYC 255
`define BOT_OFS_RESET     8'sh00
`define BOT_RSVD_LEVEL    1'b0

`endif

/* shared/bot_pkg.sv */
// types shared by both ends of the bit-stream link
package bot_pkg;

  typedef enum logic [1:0] {BOT_SRC_INPUT, BOT_SRC_ALT, BOT_SRC_PROC} bot_tick_src_t;

  typedef enum logic [1:0] {BOT_OFS_IDLE, BOT_OFS_ARMED, BOT_OFS_RUN} bot_ofs_state_t;

  typedef logic [3:0] bot_streams_t;

endpackage

/* shared/bot_link_if.sv */
// one-way cable bundle between the transport end and the acquisition/processor end
interface bot_link_if (
  input wire logic link_clk
);

  // acquisition side toward the input module
  bot_pkg::bot_streams_t in_stream;
  logic                  input_second_tick;
  logic                  alternate_second_tick;
  logic                  input_valid_marker;
  logic                  input_aux_data;
  logic                  in_rsvd;

  // output module toward the downstream processor
  logic                  reconstructed_bit_clock;
  bot_pkg::bot_streams_t reconstructed_bit_stream;
  logic                  reconstructed_second_tick;
  logic                  output_valid_flag;
  logic                  output_aux_data;
  logic                  out_rsvd;

  // processor side toward the output module, on a cable of its own
  logic                  processor_side_clock;
  logic                  processor_side_second_tick;
  logic                  proc_rsvd;

  modport xport (
    input  link_clk,
    input  in_stream,
    input  input_second_tick,
    input  alternate_second_tick,
    input  input_valid_marker,
    input  input_aux_data,
    input  in_rsvd,
    output reconstructed_bit_clock,
    output reconstructed_bit_stream,
    output reconstructed_second_tick,
    output output_valid_flag,
    output output_aux_data,
    output out_rsvd,
    input  processor_side_clock,
    input  processor_side_second_tick,
    input  proc_rsvd
  );

  modport far (
    output in_stream,
    output input_second_tick,
    output alternate_second_tick,
    output input_valid_marker,
    output input_aux_data,
    output in_rsvd,
    input  reconstructed_bit_clock,
    input  reconstructed_bit_stream,
    input  reconstructed_second_tick,
    input  output_valid_flag,
    input  output_aux_data,
    input  out_rsvd,
    output processor_side_clock,
    output processor_side_second_tick,
    output proc_rsvd
  );

endinterface

/* logic/bot_delay_line.sv */
// circular delay line with a variable read tap, advanced once per bit
`include "bot_regs.svh"

module bot_delay_line #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // write side
  input  wire logic             shift_in,
  input  wire logic [WIDTH-1:0] data_in,
  // read side, delay is tap plus one bit
  input  wire logic [4:0]       tap_in,
  output logic      [WIDTH-1:0] data_out
);

  logic [WIDTH-1:0] mem [`BOT_DEPTH];
  logic [4:0]       wr_ptr_reg;
  logic [4:0]       wr_ptr_next;
  logic [WIDTH-1:0] data_reg;
  wire  [4:0]       rd_ptr;

  assign wr_ptr_next = wr_ptr_reg + 5'h01;
  assign rd_ptr      = wr_ptr_reg - tap_in - 5'h01;
  assign data_out    = data_reg;

  // storage is not reset; the owner keeps the output invalid until it has refilled
  always_ff @(posedge clk_in)
  begin
    if (shift_in)
    begin
      mem[wr_ptr_reg] <= data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_reg <= 5'h00;
      data_reg   <= '0;
    end
    else if (shift_in)
    begin
      wr_ptr_reg <= wr_ptr_next;
      data_reg   <= mem[rd_ptr];
    end
  end

endmodule

/* logic/bot_transport_end.sv */
// transport end: input sampling, stream routing, delay offset and reconstructed output timing
`include "bot_regs.svh"

module bot_transport_end (
  // link, clocked by the link clock
  bot_link_if.xport        link,
  // reset
  input  wire logic        nrst_in,
  // delay-offset command
  input  wire logic        offset_cmd_in,
  input  wire logic signed [7:0] offset_start_in,
  input  wire logic signed [7:0] offset_rate_in,
  input  wire logic [15:0] offset_tag_in,
  // stream selection and timing setup
  input  wire logic [1:0]  active_log2_in,
  input  wire logic [7:0]  route_sel_in,
  input  wire logic [1:0]  rate_log2_in,
  input  wire logic        biphase_en_in,
  input  wire logic [1:0]  tick_src_in,
  // status
  output logic             synced_out,
  output logic [15:0]      second_count_out,
  output logic signed [7:0] applied_offset_out,
  output logic             proc_clk_active_out,
  output logic             in_monitor_tick_out,
  output logic             out_monitor_tick_out
);

  localparam int NS = `BOT_NSTREAM;
  localparam int NSYNC = NS + 6;

  // stretch counter: reload on a trigger, else run down to zero
  function automatic logic [6:0] stretch_next(input logic [6:0] cnt, input logic trig);
    logic [6:0] res;
    res = (cnt != 7'h00) ? cnt - 7'h01 : 7'h00;
    if (trig)
    begin
      res = 7'(`BOT_STRETCH_CYC);
    end
    return res;
  endfunction

  // signed add that clips to the reach of the delay line
  function automatic logic signed [7:0] ofs_clip(input logic signed [8:0] val);
    logic signed [7:0] res;
    res = val[7:0];
    if (val < 9'(`BOT_OFS_MIN))
    begin
      res = 8'(`BOT_OFS_MIN);
    end
    else if (val > 9'(`BOT_OFS_MAX))
    begin
      res = 8'(`BOT_OFS_MAX);
    end
    return res;
  endfunction

  wire logic clk = link.link_clk;

  // reset synchroniser; a reset after any clock rate change restarts every counter
  logic nrst_meta_reg;
  logic nrst_reg;
  always_ff @(posedge clk)
  begin
    nrst_meta_reg <= nrst_in;
    nrst_reg      <= nrst_meta_reg;
  end

  // pin synchronisers: streams, input tick, alternate tick, valid, aux, proc clock, proc tick
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic [3:0]       edge_prev_reg;
  always_ff @(posedge clk)
  begin
    meta_reg <= {link.processor_side_second_tick, link.processor_side_clock, link.input_aux_data,
                 link.input_valid_marker, link.alternate_second_tick, link.input_second_tick,
                 link.in_stream};
    sync_reg <= meta_reg;
  end

  wire bot_pkg::bot_streams_t in_samp = sync_reg[NS-1:0];
  wire logic in_tick     = sync_reg[NS];
  wire logic alt_tick    = sync_reg[NS+1];
  wire logic in_valid    = sync_reg[NS+2];
  wire logic in_aux      = sync_reg[NS+3];
  wire logic proc_clk    = sync_reg[NS+4];
  wire logic proc_tick   = sync_reg[NS+5];

  // tick source choice; the processor tick is optional so standalone use needs none
  wire bot_pkg::bot_tick_src_t src = bot_pkg::bot_tick_src_t'(tick_src_in);
  logic sel_tick;
  always_comb
  begin
    unique case (src)
      bot_pkg::BOT_SRC_INPUT: sel_tick = in_tick;
      bot_pkg::BOT_SRC_ALT:   sel_tick = alt_tick;
      bot_pkg::BOT_SRC_PROC:  sel_tick = proc_tick;
      default:                sel_tick = in_tick;
    endcase
  end
  wire logic sel_prev   = (src == bot_pkg::BOT_SRC_ALT) ? edge_prev_reg[1] :
                          (src == bot_pkg::BOT_SRC_PROC) ? edge_prev_reg[3] : edge_prev_reg[0];
  wire logic tick_edge  = sel_tick & ~sel_prev;
  wire logic pclk_edge  = proc_clk & ~edge_prev_reg[2];

  // bit clock phase and bit cells; one bit spans 2^rate bit clock cycles
  logic [1:0] phase_reg;
  logic [2:0] cell_reg;
  wire logic [2:0] cell_last = 3'((1 << rate_log2_in) - 1);
  wire logic cell_end        = (phase_reg == 2'(`BOT_REC_DIV - 1));
  wire logic bit_end         = cell_end && (cell_reg == cell_last);

  // routing: output j takes active input sel_j, out-of-set picks are flagged
  bot_pkg::bot_streams_t routed;
  bot_pkg::bot_streams_t route_ok;
  always_comb
  begin
    for (int j = 0; j < NS; j++)
    begin
      routed[j]   = in_samp[route_sel_in[2*j +: 2]];
      route_ok[j] = ({2'b00, route_sel_in[2*j +: 2]} < 4'(1 << active_log2_in));
    end
  end

  // offset model state
  bot_pkg::bot_ofs_state_t ofs_state_reg;
  logic signed [7:0] ofs_reg;
  logic signed [7:0] rate_reg;
  logic signed [7:0] start_reg;
  logic [15:0]       tag_reg;
  logic [15:0]       sec_reg;
  logic [5:0]        settle_reg;
  logic              tick_pend_reg;
  logic [11:0]       pidle_reg;
  logic [6:0]        in_mon_reg;
  logic [6:0]        out_mon_reg;

  wire logic [4:0] tap = 5'(`BOT_BASE_TAP + ofs_reg);
  wire logic       synced = (ofs_state_reg != bot_pkg::BOT_OFS_ARMED) && (settle_reg == 6'h00);

  // delay line entry: streams, tick, carried valid, aux; tick rides with the data
  wire logic [NS+2:0] dl_in = {in_aux, in_valid, tick_pend_reg | tick_edge, routed};
  logic [NS+2:0]      dl_out;

  bot_delay_line #(
    .WIDTH (NS + 3)
  ) u_delay (
    .clk_in   (clk),
    .nrst_in  (nrst_reg),
    .shift_in (bit_end),
    .data_in  (dl_in),
    .tap_in   (tap),
    .data_out (dl_out)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst_reg)
    begin
      edge_prev_reg <= 4'h0;
      phase_reg     <= 2'h0;
      cell_reg      <= 3'h0;
      tick_pend_reg <= 1'b0;
      pidle_reg     <= 12'h000;
    end
    else
    begin
      edge_prev_reg <= {proc_tick, proc_clk, alt_tick, in_tick};
      phase_reg     <= phase_reg + 2'h1;
      if (cell_end)
      begin
        cell_reg <= bit_end ? 3'h0 : cell_reg + 3'h1;
      end
      // a tick seen in a write cycle goes straight into that entry; keeping it pending would mark two bits
      tick_pend_reg <= (tick_edge | tick_pend_reg) & ~bit_end;
      if (pclk_edge)
      begin
        pidle_reg <= 12'h000;
      end
      else if (pidle_reg != 12'(`BOT_PROC_IDLE_CYC))
      begin
        pidle_reg <= pidle_reg + 12'h001;
      end
    end
  end

  // second count, tagged start and per-second rate
  always_ff @(posedge clk)
  begin
    if (!nrst_reg)
    begin
      ofs_state_reg <= bot_pkg::BOT_OFS_IDLE;
      ofs_reg       <= `BOT_OFS_RESET;
      rate_reg      <= 8'sh00;
      start_reg     <= 8'sh00;
      tag_reg       <= 16'h0000;
      sec_reg       <= 16'h0000;
      settle_reg    <= 6'(`BOT_SETTLE_BITS);
    end
    else
    begin
      if (tick_edge)
      begin
        sec_reg <= sec_reg + 16'h0001;
      end
      if (bit_end && settle_reg != 6'h00)
      begin
        settle_reg <= settle_reg - 6'h01;
      end
      unique case (ofs_state_reg)
        bot_pkg::BOT_OFS_IDLE, bot_pkg::BOT_OFS_RUN:
        begin
          if (tick_edge && ofs_state_reg == bot_pkg::BOT_OFS_RUN && rate_reg != 8'sh00)
          begin
            ofs_reg    <= ofs_clip(9'(ofs_reg) + 9'(rate_reg));
            settle_reg <= 6'(`BOT_SETTLE_BITS);
          end
        end
        bot_pkg::BOT_OFS_ARMED:
        begin
          if (tick_edge && sec_reg + 16'h0001 == tag_reg)
          begin
            ofs_reg       <= ofs_clip(9'(start_reg));
            settle_reg    <= 6'(`BOT_SETTLE_BITS);
            ofs_state_reg <= bot_pkg::BOT_OFS_RUN;
          end
        end
        default:
        begin
          ofs_state_reg <= bot_pkg::BOT_OFS_IDLE;
        end
      endcase
      // a new command overrides any model in progress and waits for its tag
      if (offset_cmd_in)
      begin
        start_reg     <= offset_start_in;
        rate_reg      <= offset_rate_in;
        tag_reg       <= offset_tag_in;
        ofs_state_reg <= bot_pkg::BOT_OFS_ARMED;
      end
    end
  end

  // output launch, registered on the same edge as the bit clock rises
  logic                  rclk_reg;
  bot_pkg::bot_streams_t rbs_reg;
  logic                  rtick_reg;
  logic                  rvalid_reg;
  logic                  raux_reg;
  bot_pkg::bot_streams_t bad_reg;
  logic                  tick_prev_reg;

  wire logic valid_next = synced & dl_out[NS+1];
  wire logic first_half = (phase_reg < 2'(`BOT_REC_DIV / 2));
  wire logic launch     = (phase_reg == 2'h0);
  wire bot_pkg::bot_streams_t bit_bad = ~route_ok | {NS{~valid_next}};
  // second half toggles only for a bad bit, so plain streams read fully valid
  wire bot_pkg::bot_streams_t line_next = first_half ? dl_out[NS-1:0] : dl_out[NS-1:0] ^ bad_reg;
  // one bit clock cycle of the first cell, clipped to 500 ns; an entry re-read after a one-bit tap
  // step must not stretch the tick
  wire logic tick_next = dl_out[NS] && !tick_prev_reg && cell_reg == 3'h0 && {30'h0, phase_reg} < `BOT_R1_MAX_CYC;

  always_ff @(posedge clk)
  begin
    if (!nrst_reg)
    begin
      rclk_reg    <= 1'b0;
      rbs_reg     <= '0;
      rtick_reg   <= 1'b0;
      rvalid_reg  <= 1'b0;
      raux_reg    <= 1'b0;
      in_mon_reg  <= 7'h00;
      out_mon_reg <= 7'h00;
      bad_reg     <= '0;
      tick_prev_reg <= 1'b0;
    end
    else
    begin
      rclk_reg    <= first_half;
      rbs_reg     <= line_next;
      rtick_reg   <= tick_next;
      raux_reg    <= dl_out[NS+2];
      // validity frozen per bit clock cycle, so the receiver never sees it move inside a half cell
      if (launch)
      begin
        rvalid_reg <= valid_next;
        bad_reg    <= biphase_en_in ? bit_bad : '0;
      end
      if (bit_end)
      begin
        tick_prev_reg <= dl_out[NS];
      end
      in_mon_reg  <= stretch_next(in_mon_reg, tick_edge);
      out_mon_reg <= stretch_next(out_mon_reg, tick_next & ~rtick_reg);
    end
  end

  // all cable lines driven, reserved line held constant, outputs only
  assign link.reconstructed_bit_clock   = rclk_reg;
  assign link.reconstructed_bit_stream  = rbs_reg;
  assign link.reconstructed_second_tick = rtick_reg;
  assign link.output_valid_flag         = rvalid_reg;
  assign link.output_aux_data           = raux_reg;
  assign link.out_rsvd                  = `BOT_RSVD_LEVEL;

  assign synced_out           = synced;
  assign second_count_out     = sec_reg;
  assign applied_offset_out   = ofs_reg;
  assign proc_clk_active_out  = (pidle_reg != 12'(`BOT_PROC_IDLE_CYC));
  assign in_monitor_tick_out  = (in_mon_reg != 7'h00);
  assign out_monitor_tick_out = (out_mon_reg != 7'h00);

endmodule

/* logic/bot_far_end.sv */
// far end: acquisition source, processor clock and tick source, bi-phase receiver
`include "bot_regs.svh"

module bot_far_end (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  // link
  bot_link_if.far                    link,
  // acquisition data
  input  wire bot_pkg::bot_streams_t acq_stream_in,
  input  wire logic                  acq_valid_in,
  input  wire logic                  acq_aux_in,
  // second tick requests
  input  wire logic                  tick_req_in,
  input  wire logic                  alt_tick_in,
  // receiver setup
  input  wire logic                  biphase_en_in,
  // received data
  output logic [3:0]                 rx_bit_out,
  output logic [3:0]                 rx_bit_valid_out,
  output logic                       rx_strobe_out,
  output logic                       rx_tick_out,
  output logic                       rx_valid_out,
  output logic                       rx_aux_out
);

  logic [3:0] acq_reg;
  logic       acq_valid_reg;
  logic       acq_aux_reg;
  logic       alt_reg;
  logic       pclk_reg;
  logic [2:0] tick_cnt_reg;

  // tick held a fixed count: at least one link and processor clock, under 500 ns
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      acq_reg       <= 4'h0;
      acq_valid_reg <= 1'b0;
      acq_aux_reg   <= 1'b0;
      alt_reg       <= 1'b0;
      pclk_reg      <= 1'b0;
      tick_cnt_reg  <= 3'h0;
    end
    else
    begin
      acq_reg       <= acq_stream_in;
      acq_valid_reg <= acq_valid_in;
      acq_aux_reg   <= acq_aux_in;
      alt_reg       <= alt_tick_in;
      pclk_reg      <= ~pclk_reg;
      if (tick_req_in && tick_cnt_reg == 3'h0)
      begin
        tick_cnt_reg <= 3'(`BOT_TICK_CYC);
      end
      else if (tick_cnt_reg != 3'h0)
      begin
        tick_cnt_reg <= tick_cnt_reg - 3'h1;
      end
    end
  end

  // one-way lines only, reserved lines at a constant level
  assign link.in_stream                  = acq_reg;
  assign link.input_second_tick          = (tick_cnt_reg != 3'h0);
  assign link.alternate_second_tick      = alt_reg;
  assign link.input_valid_marker         = acq_valid_reg;
  assign link.input_aux_data             = acq_aux_reg;
  assign link.in_rsvd                    = `BOT_RSVD_LEVEL;
  assign link.processor_side_clock       = pclk_reg;
  assign link.processor_side_second_tick = (tick_cnt_reg != 3'h0);
  assign link.proc_rsvd                  = `BOT_RSVD_LEVEL;

  // receiver: clock, streams, tick, valid, aux through two flops
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic [7:0] last_reg;
  always_ff @(posedge clk_in)
  begin
    meta_reg <= {link.output_aux_data, link.output_valid_flag, link.reconstructed_second_tick,
                 link.reconstructed_bit_stream, link.reconstructed_bit_clock};
    sync_reg <= meta_reg;
  end

  wire logic rise = sync_reg[0] & ~last_reg[0];
  wire logic fall = ~sync_reg[0] & last_reg[0];

  logic [3:0] half1_reg;
  logic [2:0] side_reg;
  logic [3:0] bit_reg;
  logic [3:0] bval_reg;
  logic       strobe_reg;
  logic [2:0] side_out_reg;

  // first half caught at the falling edge, compared with the second half at the rise
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      last_reg     <= 8'h00;
      half1_reg    <= 4'h0;
      side_reg     <= 3'h0;
      bit_reg      <= 4'h0;
      bval_reg     <= 4'h0;
      strobe_reg   <= 1'b0;
      side_out_reg <= 3'h0;
    end
    else
    begin
      last_reg   <= sync_reg;
      strobe_reg <= rise;
      if (fall)
      begin
        half1_reg <= last_reg[4:1];
        side_reg  <= last_reg[7:5];
      end
      if (rise)
      begin
        bit_reg      <= half1_reg;
        bval_reg     <= biphase_en_in ? ~(half1_reg ^ last_reg[4:1]) : 4'hF;
        side_out_reg <= side_reg;
      end
    end
  end

  assign rx_bit_out       = bit_reg;
  assign rx_bit_valid_out = bval_reg;
  assign rx_strobe_out    = strobe_reg;
  assign rx_tick_out      = side_out_reg[0];
  assign rx_valid_out     = side_out_reg[1];
  assign rx_aux_out       = side_out_reg[2];

endmodule

/* test/bot_link_props.sv */
// link checks between the transport end and the far end
`include "bot_regs.svh"

module bot_link_props (
  // clock and reset
  input wire logic                  link_clk,
  input wire logic                  nrst_in,
  // link lines
  input wire logic                  reconstructed_bit_clock,
  input wire bot_pkg::bot_streams_t reconstructed_bit_stream,
  input wire logic                  reconstructed_second_tick,
  input wire logic                  output_valid_flag,
  input wire logic                  input_valid_marker,
  input wire logic                  input_second_tick,
  input wire logic                  in_rsvd,
  input wire logic                  out_rsvd,
  input wire logic                  proc_rsvd
);
  wire logic  c  = reconstructed_bit_clock;
  wire logic  tk = reconstructed_second_tick;
  wire logic  vf = output_valid_flag;
  wire logic  it = input_second_tick;
  logic [8:0] low_cnt_reg;
  // 300 cycles outlasts the deepest delay at rate_log2_in 0 or 1 (not 2 or 3), so the carried marker must be low by then
  always_ff @(posedge link_clk)
  begin
    if (!nrst_in || input_valid_marker)
      low_cnt_reg <= 9'h000;
    else if (low_cnt_reg != 9'h1FF)
      low_cnt_reg <= low_cnt_reg + 9'h001;
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!nrst_in);
  tick_width_a: assert property ($rose(tk) |-> tk[*4] ##1 !tk) else $error("output tick width");
  tick_launch_a: assert property ($rose(tk) |-> $rose(c)) else $error("tick off clock rise");
  clock_shape_a: assert property ($rose(c) |-> c[*2] ##1 !c[*2] ##1 c) else $error("bit clock shape");
  data_launch_a: assert property ($changed(reconstructed_bit_stream) |-> $changed(c)) else $error("data moved");
  valid_launch_a: assert property ($changed(vf) |-> $rose(c)) else $error("valid off clock rise");
  valid_gate_a: assert property (low_cnt_reg >= 9'h12C |-> !vf) else $error("valid without marker");
  out_rsvd_a: assert property (out_rsvd == `BOT_RSVD_LEVEL) else $error("reserved out line moved");
  far_rsvd_a: assert property (!in_rsvd && !proc_rsvd) else $error("reserved far line moved");
  in_tick_a: assert property ($rose(it) |=> it ##[1:5] !it) else $error("input tick width");
endmodule

/* test/test_bitstream_output_timing_validity.sv */
// self-checking bench joining the transport end and the far end
`include "bot_regs.svh"

module test_bitstream_output_timing_validity;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_in = 1'b0;
  logic                  link_clk = 1'b0;
  logic                  nrst_in = 1'b0;
  logic                  offset_cmd = 1'b0;
  logic signed [7:0]     ofs_start = 8'sh00;
  logic signed [7:0]     ofs_rate = 8'sh00;
  logic [15:0]           ofs_tag = 16'h0000;
  logic [1:0]            act = 2'h2;
  logic [7:0]            route = 8'hE4;
  logic                  biph = 1'b0;
  logic [1:0]            src = 2'h0;
  logic [1:0]            rate = 2'h0;
  bot_pkg::bot_streams_t acq = 4'h0;
  logic                  acq_valid = 1'b1;
  logic                  acq_aux = 1'b0;
  logic                  tick_req = 1'b0;
  logic                  alt_tick = 1'b0;
  logic                  want = 1'b0;
  logic                  synced, proc_act, rx_strobe, rx_valid, rx_aux, in_mon;
  logic [15:0]           sec_cnt, last_cnt;
  logic signed [7:0]     applied;
  logic [3:0]            rx_bit, rx_bv;
  logic [31:0]           seed = 32'h00008E46;
  logic [15:0]           ofs_q[$];
  logic [15:0]           rx_q[$];
  int                    mismatches = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  int                    m_cnt = 0, m_ofs = 0, m_st = 0, m_rt = 0, m_tag = 0;
  bit                    armed = 1'b0, run = 1'b0;

  initial forever #50 clk_in = ~clk_in;
  initial
  begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  bot_link_if bot_link_if_i (.link_clk(link_clk));
  bot_transport_end bot_transport_end_i (
    .link(bot_link_if_i), .nrst_in(nrst_in), .offset_cmd_in(offset_cmd), .offset_start_in(ofs_start),
    .offset_rate_in(ofs_rate), .offset_tag_in(ofs_tag), .active_log2_in(act), .route_sel_in(route),
    .rate_log2_in(rate), .biphase_en_in(biph), .tick_src_in(src), .synced_out(synced),
    .second_count_out(sec_cnt), .applied_offset_out(applied), .proc_clk_active_out(proc_act),
    .in_monitor_tick_out(in_mon), .out_monitor_tick_out());
  bot_far_end bot_far_end_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .link(bot_link_if_i), .acq_stream_in(acq), .acq_valid_in(acq_valid),
    .acq_aux_in(acq_aux), .tick_req_in(tick_req), .alt_tick_in(alt_tick), .biphase_en_in(biph),
    .rx_bit_out(rx_bit), .rx_bit_valid_out(rx_bv), .rx_strobe_out(rx_strobe), .rx_tick_out(),
    .rx_valid_out(rx_valid), .rx_aux_out(rx_aux));
  bot_link_props bot_link_props_i (
    .link_clk(link_clk), .nrst_in(nrst_in),
    .reconstructed_bit_clock(bot_link_if_i.reconstructed_bit_clock),
    .reconstructed_bit_stream(bot_link_if_i.reconstructed_bit_stream),
    .reconstructed_second_tick(bot_link_if_i.reconstructed_second_tick),
    .output_valid_flag(bot_link_if_i.output_valid_flag), .input_valid_marker(bot_link_if_i.input_valid_marker),
    .input_second_tick(bot_link_if_i.input_second_tick), .in_rsvd(bot_link_if_i.in_rsvd),
    .out_rsvd(bot_link_if_i.out_rsvd), .proc_rsvd(bot_link_if_i.proc_rsvd));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int clip(input int v);
    return v < `BOT_OFS_MIN ? `BOT_OFS_MIN : (v > `BOT_OFS_MAX ? `BOT_OFS_MAX : v);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic lk(input int n);
    repeat (n) @(posedge link_clk);
    #5;
  endtask

  task automatic ck(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask

  // a tick of the unselected source must leave the count alone
  task automatic tick(input logic alt);
    int n;
    if (alt == (src == 2'h1))
    begin
      m_cnt++;
      if (armed && m_cnt == m_tag)
      begin
        m_ofs = clip(m_st);
        armed = 1'b0;
        run = 1'b1;
      end
      else if (run && m_rt != 0)
        m_ofs = clip(m_ofs + m_rt);
      ofs_q.push_back(16'(m_ofs));
    end
    ck(1);
    tick_req = !alt;
    alt_tick = alt;
    ck(1);
    tick_req = 1'b0;
    ck(3);
    alt_tick = 1'b0;
    for (n = 0; n < 40 && sec_cnt !== 16'(m_cnt); n++)
      lk(1);
    if (alt == (src == 2'h1))
      check(16'(in_mon), 16'h0001);
    lk(20);
  endtask

  task automatic cmd(input int s, input int r, input logic [1:0] sel);
    lk(1);
    src = sel;
    m_st = s;
    m_rt = r;
    m_tag = m_cnt + 1;
    armed = 1'b1;
    run = 1'b0;
    ofs_start = 8'(s);
    ofs_rate = 8'(r);
    ofs_tag = 16'(m_tag);
    offset_cmd = 1'b1;
    lk(1);
    offset_cmd = 1'b0;
    lk(1);
    check(16'(synced), 16'h0000);
  endtask

  always @(negedge link_clk)
  begin
    if (nrst_in && sec_cnt !== last_cnt)
      check(16'(applied), ofs_q.size() > 0 ? ofs_q.pop_front() : 16'h8000);
    last_cnt = sec_cnt;
  end

  always @(negedge clk_in)
  begin
    if (want && rx_strobe)
    begin
      check({3'h0, rx_aux, rx_bv, 4'h0, rx_bit}, rx_q.pop_front());
      want = 1'b0;
    end
  end

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [3:0]  eb, ev;
    int          j, k, n;
    ck(12);
    nrst_in = 1'b1;
    lk(4);
    check(16'({synced, bot_link_if_i.output_valid_flag}), 16'h0000);
    lk(300);
    for (k = 0; k < 6; k++)
    begin
      r = rnd();
      biph = k[0];
      act = 2'(k / 2);
      rate = {1'b0, k[1]};
      route = r[7:0];
      ck(1);
      acq = r[11:8];
      acq_aux = r[12];
      for (j = 0; j < 4; j++)
      begin
        eb[j] = r[8 + r[2*j +: 2]];
        ev[j] = !(biph && r[2*j +: 2] >= (1 << act));
      end
      lk(300);
      rx_q.push_back({3'h0, acq_aux, ev, 4'h0, eb});
      want = 1'b1;
      for (n = 0; n < 20 && want; n++)
        ck(1);
    end
    check(16'(rx_q.size()), 16'h0000);
    $display("routing test done");
    cmd(3, -2, 2'h0);
    tick(1'b0);
    tick(1'b0);
    tick(1'b1);
    tick(1'b0);
    cmd(14, 5, 2'h1);
    tick(1'b1);
    tick(1'b0);
    tick(1'b1);
    tick(1'b1);
    cmd(-20, 0, 2'h2);
    tick(1'b0);
    tick(1'b0);
    $display("offset test done");
    for (n = 0; n < 400 && synced !== 1'b1; n++)
      lk(1);
    lk(8);
    check(16'({synced, bot_link_if_i.output_valid_flag, proc_act}), 16'h0007);
    ck(1);
    acq_valid = 1'b0;
    lk(300);
    check(16'({bot_link_if_i.output_valid_flag, rx_valid}), 16'h0000);
    $display("valid test done");
    summarize();
  end
endmodule
